//--- design/boot_seq_regs.svh
// Register offsets, field positions, reset values and timing figures of the sequencer.
`ifndef BOOT_SEQ_REGS_SVH
`define BOOT_SEQ_REGS_SVH

// Clock rate and analog figures the counts derive from.
`define CLK_KHZ 10000
`define SLEW_UV_PER_MS 2500
`define VID_LSB_UV 6250
`define PG_MARGIN_UV 300000
`define CMD_READY_MS 2
`define CMD_READY_CYC (`CMD_READY_MS * `CLK_KHZ)
`define PG_DELAY_US 10
`define PG_DELAY_CYC (`PG_DELAY_US * `CLK_KHZ / 1000)

// Default boot code table, one byte per sampled pin pair {clock pin, data pin}.
`define BOOT_TABLE_DEF 32'h40302010

// Register byte offsets.
`define CTRL_OFF 8'h00
`define STAT_OFF 8'h04
`define CODE_OFF 8'h08

// Control register fields and reset value.
`define CTRL_FORCE_ALERT 0
`define CTRL_RESET 1'b0

// Status register fields.
`define STAT_FAULT_LSB 0
`define STAT_READY_BIT 6
`define STAT_CMD_BIT 7
`define STAT_STATE_LSB 8
`define STAT_PG_PIN_BIT 15
`define STAT_ALERT_PIN_BIT 16
`define STAT_BOOT_LSB 24

// Code register fields.
`define CODE_CORE_LSB 0
`define CODE_NB_LSB 8
`define CODE_THR_LSB 16

`endif

//--- design/boot_seq_pkg.sv
// Types shared by the boot sequencer modules.
package boot_seq_pkg;
  typedef logic [7:0] vid_code_t;
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_WAIT_EN = 7'h02,
    ST_LATCH = 7'h04,
    ST_RAMP_UP = 7'h08,
    ST_PG_WAIT = 7'h10,
    ST_ON = 7'h20,
    ST_RAMP_DOWN = 7'h40
  } seq_state_t;
endpackage

//--- design/boot_lut_if.sv
// Lookup request and answer between the sequencer and its boot code table.
interface boot_lut_if;
  import boot_seq_pkg::*;
  logic [1:0] pins;
  logic req;
  vid_code_t code;
  modport seq (output pins, output req, input code);
  modport lut (input pins, input req, output code);
endinterface

//--- design/boot_code_table.sv
// Parameterised table that maps the two sampled pin levels to a boot code.
`include "boot_seq_regs.svh"

module boot_code_table
  import boot_seq_pkg::*;
#(
  parameter logic [31:0] TABLE = `BOOT_TABLE_DEF
) (
  input wire logic clock,
  input wire logic rst,
  boot_lut_if.lut lut
);
  vid_code_t code_ff;
  vid_code_t nxt_code;

  // A request selects one byte of the table; the answer holds until the next request.
  always_comb begin
    nxt_code = code_ff;
    if (lut.req) begin
      nxt_code = TABLE[{lut.pins, 3'b000} +: 8];
    end
  end

  // Registered read data.
  always_ff @(posedge clock) begin
    if (rst) begin
      code_ff <= 8'h00;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign lut.code = code_ff;
endmodule

//--- design/boot_vid_startup_sequencer.sv
// Start-up, boot code capture, reference ramp and protection sequencer with Wishbone registers.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`include "boot_seq_regs.svh"

// Operation
// - Power-ready is high only while main and driver supply comparators are both good.
// - Start-up of both rails begins only with power-ready high and enable high.
// - Losing main supply power-ready disables everything at once.
// - Serial voltage command interface is ready within 2ms of enable.
// - Protection latches clear only while power-ready is low.
// - Dropping enable leaves tripped protection latches set.
// - Clock and data pin levels are sampled at enable rise into a boot register.
// - On enable both references ramp from zero to the boot code in continuous conduction; a re-enable during ramp-down ramps up from the present code.
// - Reference ramp moves at a fixed slew of 2.5mV/ms.
// - After soft-start, power-good rises after a delay if rails are above threshold.
// - Power-good and thermal alert stay inactive until soft-start has finished.
// - A thermal event drives the active-low thermal alert pin low.
// - Telemetry pin is driven high once the master I/O supply is ready.
// - Each rail's code is driven to its reference converter.
// - Power-good drops at once when enable goes low.
// - On disable each reference ramps down at soft-start slew in continuous conduction.
// - Any over-voltage, under-voltage or over-current latch forces power-good low.
module boot_vid_startup_sequencer
  import boot_seq_pkg::*;
#(
  parameter int LSB_UV = `VID_LSB_UV,
  parameter int STEP_CYC = (LSB_UV * `CLK_KHZ + `SLEW_UV_PER_MS - 1) / `SLEW_UV_PER_MS,
  parameter int CMD_READY_CYC = `CMD_READY_CYC,
  parameter int PG_DELAY_CYC = `PG_DELAY_CYC,
  parameter logic [31:0] BOOT_TABLE = `BOOT_TABLE_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic main_supply_ok,
  input wire logic driver_supply_ok,
  input wire logic enable_ok,
  input wire logic master_io_supply_ok,
  input wire logic serial_vid_clock_pin,
  input wire logic serial_vid_data_pin,
  input wire logic core_above_pg,
  input wire logic nb_above_pg,
  input wire logic [1:0] over_voltage_event,
  input wire logic [1:0] over_current_event,
  input wire logic [1:0] under_voltage_event,
  input wire logic thermal_event,
  input wire logic power_good_out_in,
  output logic power_good_out_drv,
  output logic power_good_out_oe,
  input wire logic thermal_alert_n_in,
  output logic thermal_alert_n_drv,
  output logic thermal_alert_n_oe,
  output logic telemetry_out_pin,
  output logic power_ready,
  output logic serial_voltage_command_ready,
  output logic continuous_conduction_mode,
  output vid_code_t core_ref_code,
  output vid_code_t northbridge_rail_ref_code,
  output vid_code_t pg_threshold_code,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  localparam int CW = 16;
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYC - 1);
  localparam logic [CW-1:0] CMD_LAST = CW'(CMD_READY_CYC - 3);
  localparam logic [CW-1:0] PG_LAST = CW'(PG_DELAY_CYC - 1);
  localparam vid_code_t PG_MARGIN = 8'(`PG_MARGIN_UV / LSB_UV);

  // Refuse counts that do not fit the counters.
  if (STEP_CYC < 1 || STEP_CYC > 65535) $error("STEP_CYC out of range");
  if (CMD_READY_CYC < 4 || CMD_READY_CYC > 65535) $error("CMD_READY_CYC out of range");
  if (PG_DELAY_CYC < 1 || PG_DELAY_CYC > 65535) $error("PG_DELAY_CYC out of range");
  if (LSB_UV < 1) $error("LSB_UV must be positive");

  boot_lut_if lut_bus ();

  boot_code_table #(.TABLE(BOOT_TABLE)) u_table (
    .clock(clock),
    .rst(rst),
    .lut(lut_bus)
  );

  seq_state_t state_ff, nxt_state;
  vid_code_t boot_ff, nxt_boot, core_ff, nxt_core, nb_ff, nxt_nb, thr_ff, nxt_thr;
  logic [CW-1:0] step_ff, nxt_step, pgcnt_ff, nxt_pgcnt, svcnt_ff, nxt_svcnt;
  logic [5:0] fault_ff, nxt_fault;
  logic en_q_ff, svrdy_ff, nxt_svrdy, alert_ff, nxt_alert, tele_ff, ccm_ff, nxt_ccm;
  logic ctrl_force_ff, nxt_ctrl_force, ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic en_rise, rails_ok, moving, tick, ss_done, active, pg_good;
  vid_code_t target;

  // Power-ready and enable edge come straight from the comparator flags.
  assign power_ready = main_supply_ok & driver_supply_ok;
  assign en_rise = enable_ok & ~en_q_ff;
  assign rails_ok = core_above_pg & nb_above_pg;
  assign moving = (state_ff == ST_RAMP_UP) || (state_ff == ST_RAMP_DOWN);
  assign target = (state_ff == ST_RAMP_UP) ? boot_ff : 8'h00;
  assign tick = moving && (step_ff == STEP_LAST);
  assign ss_done = (state_ff == ST_PG_WAIT) || (state_ff == ST_ON);
  assign active = enable_ok && (state_ff == ST_LATCH || state_ff == ST_RAMP_UP || ss_done);
  assign lut_bus.pins = {serial_vid_clock_pin, serial_vid_data_pin};

  // Sequence state, boot code and the power-good delay.
  always_comb begin
    nxt_state = state_ff;
    nxt_boot = boot_ff;
    nxt_pgcnt = 16'h0000;
    lut_bus.req = 1'b0;
    if (!power_ready) begin
      nxt_state = ST_OFF;
      nxt_boot = 8'h00;
    end else begin
      unique case (state_ff)
        ST_OFF: begin
          nxt_state = ST_WAIT_EN;
        end
        ST_WAIT_EN: begin
          if (en_rise) begin
            lut_bus.req = 1'b1;
            nxt_state = ST_LATCH;
          end
        end
        ST_LATCH: begin
          nxt_boot = lut_bus.code;
          nxt_state = enable_ok ? ST_RAMP_UP : ST_RAMP_DOWN;
        end
        ST_RAMP_UP: begin
          if (!enable_ok) begin
            nxt_state = ST_RAMP_DOWN;
          end else if (core_ff == boot_ff && nb_ff == boot_ff) begin
            nxt_state = ST_PG_WAIT;
          end
        end
        ST_PG_WAIT: begin
          if (!enable_ok) begin
            nxt_state = ST_RAMP_DOWN;
          end else if (rails_ok) begin
            if (pgcnt_ff == PG_LAST) begin
              nxt_state = ST_ON;
            end else begin
              nxt_pgcnt = pgcnt_ff + 16'h0001;
            end
          end
        end
        ST_ON: begin
          if (!enable_ok) begin
            nxt_state = ST_RAMP_DOWN;
          end
        end
        ST_RAMP_DOWN: begin
          if (en_rise) begin
            lut_bus.req = 1'b1;
            nxt_state = ST_LATCH;
          end else if (core_ff == 8'h00 && nb_ff == 8'h00) begin
            nxt_state = ST_WAIT_EN;
          end
        end
      endcase
    end
  end

  // Slew divider and the two references, one code step per divider period.
  always_comb begin
    nxt_step = 16'h0000;
    nxt_core = core_ff;
    nxt_nb = nb_ff;
    if (moving && !tick) begin
      nxt_step = step_ff + 16'h0001;
    end
    if (!power_ready) begin
      nxt_core = 8'h00;
      nxt_nb = 8'h00;
    end else if (tick) begin
      if (core_ff < target) nxt_core = core_ff + 8'h01;
      else if (core_ff > target) nxt_core = core_ff - 8'h01;
      if (nb_ff < target) nxt_nb = nb_ff + 8'h01;
      else if (nb_ff > target) nxt_nb = nb_ff - 8'h01;
    end
    nxt_ccm = power_ready && (moving || nxt_state == ST_RAMP_UP || nxt_state == ST_RAMP_DOWN);
    nxt_thr = (boot_ff > PG_MARGIN) ? boot_ff - PG_MARGIN : 8'h00;
  end

  // Protection latches, command-ready timer and thermal alert.
  always_comb begin
    nxt_fault = fault_ff | {under_voltage_event, over_current_event,
                            over_voltage_event};
    if (!power_ready) begin
      nxt_fault = 6'h00;
    end
    nxt_svcnt = 16'h0000;
    if (active) begin
      nxt_svcnt = (svcnt_ff == CMD_LAST) ? svcnt_ff : svcnt_ff + 16'h0001;
    end
    nxt_svrdy = active && (svcnt_ff == CMD_LAST);
    nxt_alert = power_ready && ss_done && (thermal_event || ctrl_force_ff);
  end

  // Power-good is combinational so that enable loss and faults pull it low at once.
  assign pg_good = (state_ff == ST_ON) && enable_ok && rails_ok && (fault_ff == 6'h00);
  assign power_good_out_drv = 1'b0;
  assign power_good_out_oe = ~pg_good;
  assign thermal_alert_n_drv = 1'b0;
  assign thermal_alert_n_oe = alert_ff;
  assign telemetry_out_pin = tele_ff;
  assign serial_voltage_command_ready = svrdy_ff;
  assign continuous_conduction_mode = ccm_ff;
  assign core_ref_code = core_ff;
  assign northbridge_rail_ref_code = nb_ff;
  assign pg_threshold_code = thr_ff;

  // Wishbone slave: one wait cycle, writes land on the acknowledged edge.
  always_comb begin
    nxt_ack = wb_cyc && wb_stb && !ack_ff;
    nxt_ctrl_force = ctrl_force_ff;
    if (wb_cyc && wb_stb && ack_ff && wb_we && wb_sel[0] && wb_adr == `CTRL_OFF) begin
      nxt_ctrl_force = wb_dat_w[`CTRL_FORCE_ALERT];
    end
    nxt_rdata = 32'h00000000;
    if (nxt_ack && !wb_we) begin
      unique case (wb_adr)
        `CTRL_OFF: nxt_rdata[`CTRL_FORCE_ALERT] = ctrl_force_ff;
        `STAT_OFF: begin
          nxt_rdata[`STAT_FAULT_LSB +: 6] = fault_ff;
          nxt_rdata[`STAT_READY_BIT] = power_ready;
          nxt_rdata[`STAT_CMD_BIT] = svrdy_ff;
          nxt_rdata[`STAT_STATE_LSB +: 7] = state_ff;
          nxt_rdata[`STAT_PG_PIN_BIT] = power_good_out_in;
          nxt_rdata[`STAT_ALERT_PIN_BIT] = thermal_alert_n_in;
          nxt_rdata[`STAT_BOOT_LSB +: 8] = boot_ff;
        end
        `CODE_OFF: begin
          nxt_rdata[`CODE_CORE_LSB +: 8] = core_ff;
          nxt_rdata[`CODE_NB_LSB +: 8] = nb_ff;
          nxt_rdata[`CODE_THR_LSB +: 8] = thr_ff;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  assign wb_ack = ack_ff;
  assign wb_dat_r = rdata_ff;

  // State registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_OFF;
      boot_ff <= 8'h00;
      core_ff <= 8'h00;
      nb_ff <= 8'h00;
      thr_ff <= 8'h00;
      step_ff <= 16'h0000;
      pgcnt_ff <= 16'h0000;
      svcnt_ff <= 16'h0000;
      fault_ff <= 6'h00;
      en_q_ff <= 1'b0;
      svrdy_ff <= 1'b0;
      alert_ff <= 1'b0;
      tele_ff <= 1'b0;
      ccm_ff <= 1'b0;
      ctrl_force_ff <= `CTRL_RESET;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      boot_ff <= nxt_boot;
      core_ff <= nxt_core;
      nb_ff <= nxt_nb;
      thr_ff <= nxt_thr;
      step_ff <= nxt_step;
      pgcnt_ff <= nxt_pgcnt;
      svcnt_ff <= nxt_svcnt;
      fault_ff <= nxt_fault;
      en_q_ff <= enable_ok;
      svrdy_ff <= nxt_svrdy;
      alert_ff <= nxt_alert;
      tele_ff <= master_io_supply_ok;
      ccm_ff <= nxt_ccm;
      ctrl_force_ff <= nxt_ctrl_force;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Helper: cycles since a start-up began without the command interface being ready.
  logic [CW:0] wait_ff;
  always_ff @(posedge clock) begin
    if (rst || !active || svrdy_ff) begin
      wait_ff <= 17'h00000;
    end else begin
      wait_ff <= wait_ff + 17'h00001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_power_loss;
    !power_ready |=> state_ff == ST_OFF && core_ff == 8'h00 && nb_ff == 8'h00;
  endproperty
  a_power_loss: assert property (p_power_loss) else $error("Power loss did not disable");

  property p_start;
    state_ff == ST_WAIT_EN && power_ready && enable_ok && !en_q_ff |=> state_ff == ST_LATCH;
  endproperty
  a_start: assert property (p_start) else $error("Enable rise did not start up");

  property p_cmd_ready;
    wait_ff < 17'(CMD_READY_CYC);
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("Command ready too late");

  property p_latch_hold;
    power_ready |=> (fault_ff & $past(fault_ff)) == $past(fault_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Fault latch lost");

  property p_boot_capture;
    state_ff == ST_LATCH && power_ready |=> boot_ff == $past(lut_bus.code);
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("Boot code not kept");

  property p_ramp_from_zero;
    state_ff == ST_LATCH && $past(state_ff) == ST_WAIT_EN |-> core_ff == 8'h00 && nb_ff == 8'h00;
  endproperty
  a_ramp_from_zero: assert property (p_ramp_from_zero) else $error("Ramp not from zero");

  property p_slew;
    power_ready && $changed(core_ff) |-> $past(step_ff) == STEP_LAST && $past(moving);
  endproperty
  a_slew: assert property (p_slew) else $error("Reference stepped off the slew");

  property p_pg_delay;
    $rose(state_ff == ST_ON) |-> $past(pgcnt_ff) == PG_LAST && $past(rails_ok);
  endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("Power-good delay wrong");

  property p_pg_gated;
    !ss_done || !enable_ok || fault_ff != 6'h00 |-> power_good_out_oe;
  endproperty
  a_pg_gated: assert property (p_pg_gated) else $error("Power-good released wrongly");

  property p_alert;
    !ss_done |=> !thermal_alert_n_oe || $past(ss_done, 2);
  endproperty
  a_alert: assert property (p_alert) else $error("Alert before soft-start end");

  property p_alert_event;
    power_ready && ss_done && thermal_event |=> thermal_alert_n_oe;
  endproperty
  a_alert_event: assert property (p_alert_event) else $error("Thermal event not shown");

  property p_fault_pg;
    $past(fault_ff) != 6'h00 && power_ready |-> power_good_out_oe;
  endproperty
  a_fault_pg: assert property (p_fault_pg) else $error("Fault left power-good high");

  property p_telemetry;
    master_io_supply_ok ##1 master_io_supply_ok |-> telemetry_out_pin;
  endproperty
  a_telemetry: assert property (p_telemetry) else $error("Telemetry pin not high");

  property p_boot_clear;
    !power_ready |=> boot_ff == 8'h00;
  endproperty
  a_boot_clear: assert property (p_boot_clear) else $error("Boot code not cleared");
endmodule

//--- dv/boot_pin_master.sv
// Behavioural processor side that presents the boot selection on the serial pins.
module boot_pin_master (
  input wire logic clock,
  input wire logic io_up,
  input wire logic [1:0] sel,
  output logic master_io_supply_ok,
  output logic serial_vid_clock_pin,
  output logic serial_vid_data_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_ff = 1'b0;

  // Unpowered pins wander every cycle so that no level is taken for granted.
  always @(posedge clock) begin
    flip_ff <= ~flip_ff;
  end

  // The selection is held on the pins from I/O supply up, well before enable.
  assign master_io_supply_ok = io_up;
  assign serial_vid_clock_pin = io_up ? sel[1] : flip_ff;
  assign serial_vid_data_pin = io_up ? sel[0] : ~flip_ff;
endmodule

//--- dv/boot_vid_startup_sequencer_tb.sv
// Self-checking bench for the boot sequencer: a table of boot selections, then edge cases.
module boot_vid_startup_sequencer_tb
  import boot_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  localparam int RDY = 8;
  localparam int PGD = 3;
  localparam int LIMIT = 20000;
  typedef struct {logic [1:0] sel; vid_code_t boot; vid_code_t thr;} row_t;
  // Pins {clock, data} pick a table byte; the threshold sits 48 codes lower, floored at 0.
  row_t rows [4] = '{'{2'h0, 8'h10, 8'h00}, '{2'h1, 8'h20, 8'h00},
                     '{2'h2, 8'h30, 8'h00}, '{2'h3, 8'h40, 8'h10}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic main_supply_ok = 1'b0;
  logic driver_supply_ok = 1'b0;
  logic enable_ok = 1'b0;
  logic io_up = 1'b0;
  logic [1:0] sel = 2'h0;
  logic core_above_pg = 1'b1;
  logic nb_above_pg = 1'b1;
  logic [1:0] over_voltage_event = 2'h0;
  logic [1:0] over_current_event = 2'h0;
  logic [1:0] under_voltage_event = 2'h0;
  logic thermal_event = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r, rd;
  logic wb_ack, master_io_supply_ok, serial_vid_clock_pin, serial_vid_data_pin;
  logic power_good_out_drv, power_good_out_oe, thermal_alert_n_drv, thermal_alert_n_oe;
  logic telemetry_out_pin, power_ready, serial_voltage_command_ready, continuous_conduction_mode;
  vid_code_t core_ref_code, northbridge_rail_ref_code, pg_threshold_code;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int lo;

  // Both open-drain pins have pull-ups and read high when released.
  wire logic pg_pin = power_good_out_oe ? power_good_out_drv : 1'b1;
  wire logic alert_pin = thermal_alert_n_oe ? thermal_alert_n_drv : 1'b1;

  boot_pin_master pins (.clock, .io_up, .sel, .master_io_supply_ok, .serial_vid_clock_pin,
    .serial_vid_data_pin);

  boot_vid_startup_sequencer #(.STEP_CYC(STEP), .CMD_READY_CYC(RDY), .PG_DELAY_CYC(PGD)) dut (
    .clock, .rst, .main_supply_ok, .driver_supply_ok, .enable_ok, .master_io_supply_ok,
    .serial_vid_clock_pin, .serial_vid_data_pin, .core_above_pg, .nb_above_pg,
    .over_voltage_event, .over_current_event, .under_voltage_event, .thermal_event,
    .power_good_out_in(pg_pin), .power_good_out_drv, .power_good_out_oe,
    .thermal_alert_n_in(alert_pin), .thermal_alert_n_drv, .thermal_alert_n_oe,
    .telemetry_out_pin, .power_ready, .serial_voltage_command_ready,
    .continuous_conduction_mode, .core_ref_code, .northbridge_rail_ref_code, .pg_threshold_code,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack);

  // The clock runs at 10 MHz.
  always #50 clock = ~clock;

  // A hang is cut short by a cycle ceiling well above the planned run.
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic Wishbone access, held until ack is sampled; read data lands in rd.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] be,
                    input logic [31:0] dat);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= be;
    wb_dat_w <= dat;
    do @(posedge clock); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic set_en(input logic v);
    @(posedge clock);
    enable_ok <= v;
    @(negedge clock);
  endtask

  // Counts cycles until power-good is released, giving up after lim cycles.
  task automatic wait_pg(input int lim);
    n = 0;
    while (power_good_out_oe !== 1'b0 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  // Counts cycles until the ramp-down has reached zero, giving up after lim cycles.
  task automatic wait_off(input int lim);
    n = 0;
    while ((core_ref_code !== 8'h00 || continuous_conduction_mode !== 1'b0) && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check_bit("telemetry_idle", 1'b0, telemetry_out_pin);
    check_bit("pg_reset", 1'b1, power_good_out_oe);
    @(posedge clock);
    io_up <= 1'b1;
    main_supply_ok <= 1'b1;
    repeat (2) @(negedge clock);
    check_bit("telemetry_up", 1'b1, telemetry_out_pin);
    check_bit("ready_one_supply", 1'b0, power_ready);
    @(posedge clock);
    driver_supply_ok <= 1'b1;
    @(negedge clock);
    check_bit("ready_both", 1'b1, power_ready);
    // Every boot selection: start-up, pin change after the rise, readback, shutdown.
    foreach (rows[i]) begin
      lo = rows[i].boot * STEP;
      @(posedge clock);
      sel <= rows[i].sel;
      set_en(1'b1);
      repeat (3) @(posedge clock);
      sel <= ~rows[i].sel;
      @(negedge clock);
      check_bit("ccm_ramp", 1'b1, continuous_conduction_mode);
      check_bit("pg_in_ramp", 1'b1, power_good_out_oe);
      repeat (RDY - 3) @(negedge clock);
      check_bit("cmd_ready", 1'b1, serial_voltage_command_ready);
      wait_pg(lo + PGD + 20);
      n += RDY;
      check_bit("ramp_time", 1'b1, n >= lo && n <= lo + PGD + 12);
      check_val("core_code", rows[i].boot, core_ref_code);
      check_val("nb_code", rows[i].boot, northbridge_rail_ref_code);
      check_val("pg_thr", rows[i].thr, pg_threshold_code);
      check_bit("ccm_done", 1'b0, continuous_conduction_mode);
      wb(1'b0, 8'h04, 4'hf, 32'h0);
      check_val("boot_reg", rows[i].boot, rd[31:24]);
      check_val("state_on", 32'h20, rd[14:8]);
      check_val("stat_pins", 32'h3, rd[16:15]);
      check_val("stat_flags", 32'h3, rd[7:6]);
      wb(1'b0, 8'h08, 4'hf, 32'h0);
      check_val("code_reg", {8'h00, rows[i].thr, rows[i].boot, rows[i].boot}, rd);
      set_en(1'b0);
      check_bit("pg_drop", 1'b1, power_good_out_oe);
      @(negedge clock);
      check_bit("ccm_down", 1'b1, continuous_conduction_mode);
      wait_off(lo + 20);
      check_bit("down_time", 1'b1, n >= lo - STEP && n < lo + 20);
      check_val("nb_zero", 32'h0, northbridge_rail_ref_code);
    end
    // A low rail holds power-good; a thermal event is ignored until soft-start ends.
    @(posedge clock);
    sel <= 2'h0;
    core_above_pg <= 1'b0;
    thermal_event <= 1'b1;
    set_en(1'b1);
    repeat (10) @(negedge clock);
    check_bit("alert_in_ramp", 1'b0, thermal_alert_n_oe);
    wait_pg(16 * STEP + PGD + 20);
    check_bit("pg_rail_low", 1'b1, power_good_out_oe);
    check_bit("alert_after", 1'b1, thermal_alert_n_oe);
    @(posedge clock);
    core_above_pg <= 1'b1;
    thermal_event <= 1'b0;
    wait_pg(PGD + 4);
    check_bit("pg_rail_ok", 1'b0, power_good_out_oe);
    check_bit("alert_clear", 1'b0, thermal_alert_n_oe);
    wb(1'b1, 8'h00, 4'h1, 32'h1);
    @(negedge clock);
    check_bit("alert_forced", 1'b1, thermal_alert_n_oe);
    check_val("drv_low", 32'h0, {power_good_out_drv, thermal_alert_n_drv});
    wb(1'b1, 8'h00, 4'h0, 32'h0);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    check_val("ctrl_lane_off", 32'h1, rd);
    wb(1'b1, 8'h00, 4'h1, 32'h0);
    wb(1'b0, 8'h0c, 4'hf, 32'h0);
    check_val("unmapped", 32'h0, rd);
    check_bit("alert_off", 1'b0, thermal_alert_n_oe);
    // Protection trips stay latched through a disable and clear only on power loss.
    @(posedge clock);
    over_voltage_event <= 2'h1;
    over_current_event <= 2'h2;
    under_voltage_event <= 2'h2;
    @(posedge clock);
    over_voltage_event <= 2'h0;
    over_current_event <= 2'h0;
    under_voltage_event <= 2'h0;
    @(negedge clock);
    check_bit("pg_fault", 1'b1, power_good_out_oe);
    set_en(1'b0);
    wait_off(16 * STEP + 20);
    set_en(1'b1);
    wait_pg(16 * STEP + PGD + 20);
    check_bit("pg_latched", 1'b1, power_good_out_oe);
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    check_val("faults_kept", 32'h29, rd[5:0]);
    @(posedge clock);
    main_supply_ok <= 1'b0;
    @(negedge clock);
    check_bit("ready_lost", 1'b0, power_ready);
    @(negedge clock);
    check_val("code_lost", 32'h0, core_ref_code);
    @(posedge clock);
    main_supply_ok <= 1'b1;
    repeat (20) @(negedge clock);
    check_val("nb_no_rise", 32'h0, northbridge_rail_ref_code);
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    check_val("faults_clear", 32'h0, rd[5:0]);
    check_val("boot_clear", 32'h0, rd[31:24]);
    report_and_stop();
  end
endmodule
